// ==== logic/shp_pkg.sv ====
// Constants, carriers and helpers of the serial host protocol select block.
// Assumes one system clock domain; all pin timing is sampled by that clock.
package shp_pkg;

  localparam int          SHP_NREG         = 9;
  localparam int          SHP_WORD_W       = 32;
  localparam logic [5:0]  SHP_MIN_CLOCKS   = 6'd32;

  // Register byte offsets
  localparam logic [7:0]  SHP_OFF_ID       = 8'h00;
  localparam logic [7:0]  SHP_OFF_RSTPWR   = 8'h04;
  localparam logic [7:0]  SHP_OFF_INPROT   = 8'h08;
  localparam logic [7:0]  SHP_OFF_OUTPROT  = 8'h0C;
  localparam logic [7:0]  SHP_OFF_WORDCTL  = 8'h10;
  localparam logic [7:0]  SHP_OFF_RANGE    = 8'h14;
  localparam logic [7:0]  SHP_OFF_ALARM    = 8'h20;
  localparam logic [7:0]  SHP_OFF_ALHI     = 8'h24;
  localparam logic [7:0]  SHP_OFF_ALLO     = 8'h28;

  localparam logic [3:0]  SHP_IDX_ID       = 4'h0;
  localparam logic [3:0]  SHP_IDX_RSTPWR   = 4'h1;
  localparam logic [3:0]  SHP_IDX_INPROT   = 4'h2;
  localparam logic [3:0]  SHP_IDX_OUTPROT  = 4'h3;
  localparam logic [3:0]  SHP_IDX_WORDCTL  = 4'h4;
  localparam logic [3:0]  SHP_IDX_RANGE    = 4'h5;
  localparam logic [3:0]  SHP_IDX_ALARM    = 4'h6;
  localparam logic [3:0]  SHP_IDX_ALHI     = 4'h7;
  localparam logic [3:0]  SHP_IDX_ALLO     = 4'h8;
  localparam logic [3:0]  SHP_IDX_NONE     = 4'hF;

  // Field positions
  localparam int          SHP_PROTO_LSB    = 0;
  localparam int          SHP_RDP_LSB      = 0;
  localparam int          SHP_SYNC_BIT     = 6;
  localparam int          SHP_SEC_LSB      = 8;
  localparam logic [1:0]  SHP_SEC_DUAL     = 2'h3;
  localparam logic [1:0]  SHP_PROTO_DEF    = 2'h0;
  localparam logic [1:0]  SHP_RDP_LEGACY   = 2'h0;
  localparam logic [31:0] SHP_REG_RESET    = 32'h0000_0000;

  // Writable bits per register
  localparam logic [31:0] SHP_WM_ID        = 32'h000F_0000;
  localparam logic [31:0] SHP_WM_RSTPWR    = 32'h0000_FF37;
  localparam logic [31:0] SHP_WM_INPROT    = 32'h0000_0003;
  localparam logic [31:0] SHP_WM_OUTPROT   = 32'h0000_0343;
  localparam logic [31:0] SHP_WM_WORDCTL   = 32'h0000_FFFF;
  localparam logic [31:0] SHP_WM_RANGE     = 32'h0000_000F;
  localparam logic [31:0] SHP_WM_ALTH      = 32'hFFFF_FFFF;

  // Command frame fields and opcodes
  localparam logic [4:0]  SHP_CMD_CLR      = 5'h18;
  localparam logic [4:0]  SHP_CMD_RDH      = 5'h19;
  localparam logic [4:0]  SHP_CMD_WR       = 5'h1A;
  localparam logic [4:0]  SHP_CMD_SET      = 5'h1B;
  localparam logic [1:0]  SHP_WR_BOTH      = 2'h0;
  localparam logic [1:0]  SHP_WR_MS        = 2'h1;
  localparam logic [1:0]  SHP_WR_LS        = 2'h2;

  // Internal source-synchronous clock timing
  localparam int          SHP_CLK_NS       = 40;
  localparam int          SHP_ICLK_HALF_NS = 80;
  localparam int          SHP_ICLK_HALF_CY = (SHP_ICLK_HALF_NS + SHP_CLK_NS - 1) / SHP_CLK_NS;

  typedef enum logic {SHP_IDLE, SHP_FRAME} shp_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
    logic alarm;
  } shp_pins_t;

  typedef struct packed {
    logic sdo0;
    logic shared_pin;
    logic strobe;
  } shp_outs_t;

  function automatic logic [3:0] shp_index(input logic [7:0] off);
    if (off == SHP_OFF_ID) return SHP_IDX_ID;
    else if (off == SHP_OFF_RSTPWR) return SHP_IDX_RSTPWR;
    else if (off == SHP_OFF_INPROT) return SHP_IDX_INPROT;
    else if (off == SHP_OFF_OUTPROT) return SHP_IDX_OUTPROT;
    else if (off == SHP_OFF_WORDCTL) return SHP_IDX_WORDCTL;
    else if (off == SHP_OFF_RANGE) return SHP_IDX_RANGE;
    else if (off == SHP_OFF_ALARM) return SHP_IDX_ALARM;
    else if (off == SHP_OFF_ALHI) return SHP_IDX_ALHI;
    else if (off == SHP_OFF_ALLO) return SHP_IDX_ALLO;
    else return SHP_IDX_NONE;
  endfunction : shp_index

  function automatic logic [31:0] shp_wmask(input logic [3:0] idx);
    case (idx)
      SHP_IDX_ID:      return SHP_WM_ID;
      SHP_IDX_RSTPWR:  return SHP_WM_RSTPWR;
      SHP_IDX_INPROT:  return SHP_WM_INPROT;
      SHP_IDX_OUTPROT: return SHP_WM_OUTPROT;
      SHP_IDX_WORDCTL: return SHP_WM_WORDCTL;
      SHP_IDX_RANGE:   return SHP_WM_RANGE;
      SHP_IDX_ALHI:    return SHP_WM_ALTH;
      SHP_IDX_ALLO:    return SHP_WM_ALTH;
      default:         return 32'h0000_0000;
    endcase
  endfunction : shp_wmask

endpackage : shp_pkg

// ==== logic/shp_serial_host.sv ====
// Serial host interface of a converter: protocol select, register file, output shifter.
// Assumes the host drives select, serial clock and input data slower than clock / 4.
`timescale 1ns/1ps
module shp_serial_host
  import shp_pkg::*;
#(
  parameter int ICLK_HALF_CY = shp_pkg::SHP_ICLK_HALF_CY
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               clock_en,
  input  wire shp_pkg::shp_pins_t pins,
  input  wire logic [15:0]        conv_result,
  output shp_pkg::shp_outs_t      outs
);
  import shp_pkg::*;

  if (ICLK_HALF_CY < 1 || ICLK_HALF_CY > 255) begin : g_chk
    $error("ICLK_HALF_CY must lie in 1..255");
  end

  localparam logic [7:0] ICLK_LAST = 8'(ICLK_HALF_CY - 1);

  logic [3:0] pin_q;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  shp_sync #(.W(4)) u_sync (
    .clock    (clock),
    .reset    (reset),
    .clock_en (clock_en),
    .d_async  ({~pins.cs_n, pins.sclk, pins.sdi, pins.alarm}),
    .q        (pin_q),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  logic cs_fall;
  logic cs_rise;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_q;
  logic alarm_q;
  // Select enters inverted, so the reset level of its stages is the idle level
  assign cs_fall   = pin_rise[3];
  assign cs_rise   = pin_fall[3];
  assign sclk_q    = pin_q[2];
  assign sclk_rise = pin_rise[2];
  assign sclk_fall = pin_fall[2];
  assign sdi_q     = pin_q[1];
  assign alarm_q   = pin_q[0];

  shp_state_t  st_reg,      st_next;
  logic [31:0] regs_reg     [SHP_NREG];
  logic [31:0] regs_next    [SHP_NREG];
  logic [31:0] sh_reg,      sh_next;
  logic [31:0] in_reg,      in_next;
  logic [5:0]  cnt_reg,     cnt_next;
  logic [5:0]  sent_reg,    sent_next;
  logic        pend_reg,    pend_next;
  logic        cap_reg,     cap_next;
  logic        sdo0_reg,    sdo0_next;
  logic        sdo1_reg,    sdo1_next;
  logic        shared_reg,  shared_next;
  logic        strobe_reg,  strobe_next;
  logic [7:0]  div_reg,     div_next;
  logic        iclk_reg,    iclk_next;
  logic        rdv_reg,     rdv_next;
  logic [15:0] rdd_reg,     rdd_next;

  logic [1:0]  proto;
  logic [1:0]  rdp;
  logic        legacy;
  logic        dual;
  logic        sync_int;
  logic        ctrl_zero;
  logic        cap_on_rise;
  logic        in_frame;
  logic        cap_ev;
  logic        launch_ev;
  logic        iclk_tick;
  logic [5:0]  launch_limit;
  logic [31:0] frame_word;

  // Mode 00 and 11 capture on rising sclk, 01 and 10 on falling
  assign proto        = regs_reg[SHP_IDX_INPROT][SHP_PROTO_LSB +: 2];
  assign rdp          = regs_reg[SHP_IDX_OUTPROT][SHP_RDP_LSB +: 2];
  assign legacy       = (rdp == SHP_RDP_LEGACY);
  assign dual         = (regs_reg[SHP_IDX_OUTPROT][SHP_SEC_LSB +: 2] == SHP_SEC_DUAL);
  assign sync_int     = regs_reg[SHP_IDX_OUTPROT][SHP_SYNC_BIT];
  assign ctrl_zero    = (regs_reg[SHP_IDX_OUTPROT][7:0] == 8'h00);
  assign cap_on_rise  = (proto[1] == proto[0]);
  assign in_frame     = (st_reg == SHP_FRAME);
  assign cap_ev       = in_frame && (cap_on_rise ? sclk_rise : sclk_fall);
  assign launch_limit = dual ? 6'd16 : 6'd32;
  assign iclk_tick    = in_frame && (div_reg == ICLK_LAST)
                        && (iclk_reg || sent_reg < launch_limit);
  assign frame_word   = rdv_reg ? {rdd_reg, 16'h0000} : {conv_result, 16'h0000};

  // Launch edge is the edge opposite capture in legacy; sclk rising or the
  // internal clock rising in source-synchronous reads.
  always_comb begin
    if (!in_frame) launch_ev = 1'b0;
    else if (legacy) launch_ev = cap_on_rise ? sclk_fall : sclk_rise;
    else if (sync_int) launch_ev = iclk_tick && !iclk_reg && (sent_reg < launch_limit);
    else launch_ev = sclk_rise && (sent_reg < launch_limit);
  end

  // Command decode of the 32-bit frame held in in_reg
  logic [4:0]  cmd_op;
  logic [1:0]  cmd_sub;
  logic [8:0]  cmd_addr;
  logic [15:0] cmd_data;
  logic [3:0]  cmd_idx;
  logic        cmd_ok;
  logic [31:0] old_word;
  logic [15:0] old_half;
  logic [15:0] new_half;
  logic [31:0] merged;
  logic        wr_en;
  assign cmd_op   = in_reg[31:27];
  assign cmd_sub  = in_reg[26:25];
  assign cmd_addr = in_reg[24:16];
  assign cmd_data = in_reg[15:0];
  assign cmd_idx  = shp_index({cmd_addr[7:2], 2'b00});
  assign cmd_ok   = cs_rise && in_frame && (cnt_reg >= SHP_MIN_CLOCKS) && !cmd_addr[8]
                    && (cmd_idx != SHP_IDX_NONE);

  always_comb begin
    if (cmd_idx == SHP_IDX_ALARM) old_word = {31'h0, alarm_q};
    else if (cmd_idx < 4'(SHP_NREG)) old_word = regs_reg[cmd_idx];
    else old_word = 32'h0000_0000;
    old_half = cmd_addr[1] ? old_word[31:16] : old_word[15:0];
    wr_en    = 1'b1;
    case (cmd_op)
      SHP_CMD_WR: begin
        if (cmd_sub == SHP_WR_MS) new_half = {cmd_data[15:8], old_half[7:0]};
        else if (cmd_sub == SHP_WR_LS) new_half = {old_half[15:8], cmd_data[7:0]};
        else if (cmd_sub == SHP_WR_BOTH) new_half = cmd_data;
        else begin
          new_half = old_half;
          wr_en    = 1'b0;
        end
      end
      SHP_CMD_SET: new_half = old_half | cmd_data;
      SHP_CMD_CLR: new_half = old_half & ~cmd_data;
      default: begin
        new_half = old_half;
        wr_en    = 1'b0;
      end
    endcase
    merged = cmd_addr[1] ? {new_half, old_word[15:0]} : {old_word[31:16], new_half};
  end

  always_comb begin
    st_next     = st_reg;
    regs_next   = regs_reg;
    sh_next     = sh_reg;
    in_next     = in_reg;
    cnt_next    = cnt_reg;
    sent_next   = sent_reg;
    pend_next   = pend_reg;
    cap_next    = cap_reg;
    sdo0_next   = sdo0_reg;
    sdo1_next   = sdo1_reg;
    rdv_next    = rdv_reg;
    rdd_next    = rdd_reg;
    div_next    = div_reg;
    iclk_next   = iclk_reg;
    strobe_next = 1'b0;

    if (cs_fall) begin
      st_next   = SHP_FRAME;
      sh_next   = frame_word;
      cnt_next  = 6'd0;
      sent_next = 6'd0;
      in_next   = 32'h0000_0000;
      div_next  = 8'h00;
      iclk_next = 1'b0;
      rdv_next  = 1'b0;
      // In legacy, modes 00 and 10 present the MSB at once, 01 and 11 at the first launch; other reads wait for the first launch
      pend_next = !legacy || proto[0];
      if (legacy && !proto[0]) begin
        sdo0_next = frame_word[31];
        sdo1_next = frame_word[30];
      end
    end else if (cs_rise && in_frame) begin
      st_next = SHP_IDLE;
      if (cmd_ok && wr_en && cmd_idx != SHP_IDX_ALARM) begin
        regs_next[cmd_idx] = (old_word & ~shp_wmask(cmd_idx))
                             | (merged & shp_wmask(cmd_idx));
      end
      if (cmd_ok && cmd_op == SHP_CMD_RDH) begin
        rdv_next = 1'b1;
        rdd_next = old_half;
      end
    end else begin
      if (cap_ev) begin
        in_next  = {in_reg[30:0], sdi_q};
        cap_next = sdi_q;
        if (cnt_reg != 6'h3F) cnt_next = cnt_reg + 6'd1;
      end
      if (launch_ev) begin
        if (!legacy) sent_next = sent_reg + 6'd1;
        if (pend_reg) begin
          pend_next = 1'b0;
          sdo0_next = sh_reg[31];
          sdo1_next = sh_reg[30];
        end else if (dual) begin
          sh_next   = {sh_reg[29:0], 2'b00};
          sdo0_next = sh_reg[29];
          sdo1_next = sh_reg[28];
        end else begin
          // Past the word, input bits follow the word out to chain devices while OUTPROT[7:0] is zero
          sh_next   = {sh_reg[30:0], ctrl_zero ? cap_reg : 1'b0};
          sdo0_next = sh_reg[30];
        end
      end
      if (in_frame && !legacy && sync_int) begin
        if (div_reg == ICLK_LAST) div_next = 8'h00;
        else div_next = div_reg + 8'h01;
        if (iclk_tick) iclk_next = !iclk_reg;
      end
    end

    // Legacy keeps strobe low; otherwise it carries the launch clock
    if (legacy || !in_frame) strobe_next = 1'b0;
    else if (sync_int) strobe_next = iclk_next;
    else strobe_next = sclk_q;

    shared_next = dual ? sdo1_next : alarm_q;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg     <= SHP_IDLE;
      for (int i = 0; i < SHP_NREG; i++) regs_reg[i] <= SHP_REG_RESET;
      sh_reg     <= 32'h0000_0000;
      in_reg     <= 32'h0000_0000;
      cnt_reg    <= 6'd0;
      sent_reg   <= 6'd0;
      pend_reg   <= 1'b0;
      cap_reg    <= 1'b0;
      sdo0_reg   <= 1'b0;
      sdo1_reg   <= 1'b0;
      shared_reg <= 1'b0;
      strobe_reg <= 1'b0;
      div_reg    <= 8'h00;
      iclk_reg   <= 1'b0;
      rdv_reg    <= 1'b0;
      rdd_reg    <= 16'h0000;
    end else if (clock_en) begin
      st_reg     <= st_next;
      regs_reg   <= regs_next;
      sh_reg     <= sh_next;
      in_reg     <= in_next;
      cnt_reg    <= cnt_next;
      sent_reg   <= sent_next;
      pend_reg   <= pend_next;
      cap_reg    <= cap_next;
      sdo0_reg   <= sdo0_next;
      sdo1_reg   <= sdo1_next;
      shared_reg <= shared_next;
      strobe_reg <= strobe_next;
      div_reg    <= div_next;
      iclk_reg   <= iclk_next;
      rdv_reg    <= rdv_next;
      rdd_reg    <= rdd_next;
    end
  end

  assign outs.sdo0       = sdo0_reg;
  assign outs.shared_pin = shared_reg;
  assign outs.strobe     = strobe_reg;

  a_default_proto: assert property (@(posedge clock)
    $past(reset) && !reset |-> proto == SHP_PROTO_DEF && rdp == SHP_RDP_LEGACY)
    else $error("protocol not default after reset");

  a_cfg_only_at_end: assert property (@(posedge clock) disable iff (reset)
    clock_en && !cs_rise |=> $stable(regs_reg[SHP_IDX_INPROT]))
    else $error("protocol changed outside frame end");

  a_cfg_applies: assert property (@(posedge clock) disable iff (reset)
    clock_en && cmd_ok && wr_en && cmd_idx == SHP_IDX_INPROT && !cmd_addr[1]
    |=> proto == $past(merged[1:0]))
    else $error("protocol write not applied at frame end");

  a_strobe_low: assert property (@(posedge clock) disable iff (reset)
    clock_en && legacy |=> !outs.strobe)
    else $error("strobe pin active in legacy mode");

  a_early_msb: assert property (@(posedge clock) disable iff (reset)
    clock_en && cs_fall && legacy && !proto[0] |=> outs.sdo0 == sh_reg[31] && !pend_reg)
    else $error("MSB not launched at select fall");

  a_late_msb: assert property (@(posedge clock) disable iff (reset)
    clock_en && cs_fall && legacy && proto[0] |=> pend_reg ##0 $stable(outs.sdo0))
    else $error("MSB launched before first clock edge");

  a_dual_shift: assert property (@(posedge clock) disable iff (reset)
    clock_en && launch_ev && dual && !pend_reg && !cs_fall && !cs_rise
    |=> sh_reg == {$past(sh_reg[29:0]), 2'b00} && outs.sdo0 == $past(sh_reg[29]))
    else $error("dual mode did not move two bits");

  a_chain_in: assert property (@(posedge clock) disable iff (reset)
    clock_en && launch_ev && legacy && !dual && !pend_reg && ctrl_zero
    && !cs_fall && !cs_rise |=> sh_reg[0] == $past(cap_reg))
    else $error("chain bit not shifted in");

  a_shared_alarm: assert property (@(posedge clock) disable iff (reset)
    clock_en && !dual |=> outs.shared_pin == $past(alarm_q))
    else $error("shared pin left alarm function");

  a_src_ext_clock: assert property (@(posedge clock) disable iff (reset)
    clock_en && in_frame && !legacy && !sync_int && !cs_rise |=> outs.strobe == $past(sclk_q))
    else $error("strobe not following external clock");
endmodule : shp_serial_host

// ==== logic/shp_sync.sv ====
// Two-stage synchroniser with edge detection for a group of pin inputs.
// Assumes inputs are asynchronous to clock; edges are reported two cycles late.
`timescale 1ns/1ps
module shp_sync #(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         clock_en,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] prev_reg;

  if (W < 1) begin : g_chk
    $error("shp_sync needs W of at least 1");
  end

  // Only the second stage reads the first one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      q_reg    <= '0;
      prev_reg <= '0;
    end else if (clock_en) begin
      meta_reg <= d_async;
      q_reg    <= meta_reg;
      prev_reg <= q_reg;
    end
  end

  assign q    = q_reg;
  assign rise = q_reg & ~prev_reg;
  assign fall = ~q_reg & prev_reg;
endmodule : shp_sync

// ==== verification/shp_host_model.sv ====
// Host controller model: drives select, serial clock and input data.
// Assumes the device samples the pins with its own clock; edges sit 4 clocks apart.
`timescale 1ns/1ps
module shp_host_model (
  input  wire logic               clock,
  input  wire logic               alarm,
  input  wire shp_pkg::shp_outs_t outs,
  output shp_pkg::shp_pins_t      pins
);
  import shp_pkg::*;

  initial pins = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0, alarm: 1'b0};
  always @(posedge clock) pins.alarm <= alarm;

  // Words are left aligned; n of 0 holds select low with the serial clock still
  task automatic xfer(input logic [1:0] m, input int n, input logic [63:0] tx,
                      output logic [63:0] rx0, output logic [63:0] rx1, output int rises);
    logic st;
    logic lat;
    rx0 = '0;
    rx1 = '0;
    rises = 0;
    st = 1'b0;
    lat = m[0];
    @(posedge clock);
    pins.sclk <= m[1];
    pins.sdi <= tx[63];
    repeat (4) @(posedge clock);
    pins.cs_n <= 1'b0;
    for (int h = 0; h <= 2 * n; h++) begin
      repeat (n == 0 ? 200 : 4) begin
        @(negedge clock);
        if (outs.strobe === 1'b1 && st === 1'b0) rises++;
        st = outs.strobe;
      end
      // Sample late in the half so the synchroniser delay has settled
      if (h > 0 && h % 2 != lat) begin
        rx0[63 - (h - 1 - lat) / 2] = outs.sdo0;
        rx1[63 - (h - 1 - lat) / 2] = outs.shared_pin;
      end
      @(posedge clock);
      if (h == 2 * n) pins.cs_n <= 1'b1;
      else pins.sclk <= ~pins.sclk;
      if (h % 2 != lat && h < 2 * n) pins.sdi <= tx[63 - (h + 1 - lat) / 2];
    end
    repeat (8) @(posedge clock);
    // Released line shows the inverse so a stale value is never mistaken for data
    pins.sdi <= ~pins.sdi;
  endtask : xfer
endmodule : shp_host_model

// ==== verification/tb_shp_serial_host.sv ====
// Self-checking bench of the serial host block against a host model.
// Assumes the host model holds the far side; all traffic goes through pins.
`timescale 1ns/1ps
module tb_shp_serial_host;
  import shp_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        alarm = 1'b0;
  logic [15:0] conv  = 16'hA5C3;
  shp_pins_t   pins;
  shp_outs_t   outs;
  int          err_total = 0;
  int          checked = 0;
  logic [1:0]  md = 2'h0;
  logic [63:0] r0;
  logic [63:0] r1;
  int          rs;
  logic [15:0] v;

  always #20 clock = ~clock;

  shp_serial_host u_shp_serial_host (.clock(clock), .reset(reset), .clock_en(1'b1),
    .pins(pins), .conv_result(conv), .outs(outs));
  shp_host_model u_shp_host_model (.clock(clock), .alarm(alarm), .outs(outs), .pins(pins));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic frm(input int n, input logic [31:0] w);
    u_shp_host_model.xfer(md, n, {w, 32'h0}, r0, r1, rs);
  endtask : frm

  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    frm(32, {SHP_CMD_WR, SHP_WR_BOTH, 1'b0, off, d});
  endtask : wr

  // Data of a read command comes out in the following frame
  task automatic rd(input logic [7:0] off, output logic [15:0] d);
    frm(32, {SHP_CMD_RDH, 2'h0, 1'b0, off, 16'h0});
    frm(32, 32'h0);
    d = r0[63:48];
  endtask : rd

  task automatic t_reset;
    logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
    chk("outputs after reset", 64'(outs), 64'h0);
    foreach (offs[i]) begin
      rd(offs[i], v);
      chk("reset value", 64'(v), 64'(SHP_REG_RESET[15:0]));
    end
    rd(8'h18, v);
    chk("unmapped read", 64'(v), 64'(conv));
    wr(SHP_OFF_ALHI, 16'h1234);
    wr(8'h26, 16'hBEEF);
    wr(SHP_OFF_ALARM, 16'hFFFF);
    rd(8'h26, v);
    chk("upper half", 64'(v), 64'hBEEF);
    rd(SHP_OFF_ALHI, v);
    chk("lower half", 64'(v), 64'h1234);
    rd(SHP_OFF_ALARM, v);
    chk("alarm flags", 64'(v), 64'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_modes;
    for (int m = 1; m < 4; m++) begin
      wr(SHP_OFF_INPROT, 16'(m));
      md = 2'(m);
      rd(SHP_OFF_INPROT, v);
      chk("protocol field", 64'(v), 64'(m));
      frm(32, 32'h0);
      chk("result word", r0[63:48], 64'(conv));
      chk("legacy strobe", 64'(rs), 64'h0);
      wr(SHP_OFF_INPROT, 16'h0000);
      md = 2'h0;
    end
    $display("t_modes done");
  endtask : t_modes

  task automatic t_short;
    frm(16, 32'hD0080003);
    chk("short frame", r0[63:48], 64'(conv));
    rd(SHP_OFF_INPROT, v);
    chk("short write kept out", 64'(v), 64'h0);
    u_shp_host_model.xfer(md, 64, {32'h0F1E2D3C, 32'h0}, r0, r1, rs);
    chk("chain lead", r0[63:48], 64'(conv));
    chk("chain through", r0[31:0], 64'h0F1E2D3C);
    $display("t_short done");
  endtask : t_short

  task automatic t_dual;
    logic [31:0] w;
    logic [15:0] e0;
    logic [15:0] e1;
    w = {conv, 16'h0};
    for (int i = 0; i < 16; i++) begin
      e0[15 - i] = w[31 - 2 * i];
      e1[15 - i] = w[30 - 2 * i];
    end
    @(posedge clock) alarm <= 1'b1;
    repeat (6) @(posedge clock);
    chk("shared alarm", 64'(outs.shared_pin), 64'h1);
    wr(SHP_OFF_OUTPROT, 16'h0300);
    @(posedge clock) alarm <= 1'b0;
    frm(16, 32'h0);
    chk("dual line 0", r0[63:48], 64'(e0));
    chk("dual line 1", r1[63:48], 64'(e1));
    wr(SHP_OFF_OUTPROT, 16'h0000);
    @(posedge clock) alarm <= 1'b1;
    repeat (6) @(posedge clock);
    chk("alarm restored", 64'(outs.shared_pin), 64'h1);
    @(posedge clock) alarm <= 1'b0;
    $display("t_dual done");
  endtask : t_dual

  task automatic t_src;
    wr(SHP_OFF_OUTPROT, 16'h0001);
    frm(32, 32'h0);
    chk("external strobe", 64'(rs), 64'd32);
    wr(SHP_OFF_OUTPROT, 16'h0041);
    frm(0, 32'h0);
    chk("internal strobe", 64'(rs), 64'd32);
    wr(SHP_OFF_OUTPROT, 16'h0000);
    frm(32, 32'h0);
    chk("legacy again", 64'(rs), 64'h0);
    $display("t_src done");
  endtask : t_src

  // A reset in mid-run must bring the protocol back to mode 00
  task automatic t_rerst;
    wr(SHP_OFF_INPROT, 16'h0003);
    md = 2'h3;
    @(posedge clock) reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    md = 2'h0;
    repeat (4) @(posedge clock);
    rd(SHP_OFF_INPROT, v);
    chk("protocol after reset", 64'(v), 64'h0);
    frm(32, 32'h0);
    chk("result after reset", r0[63:48], 64'(conv));
    $display("t_rerst done");
  endtask : t_rerst

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    t_reset();
    t_modes();
    t_short();
    t_dual();
    t_src();
    t_rerst();
    complete_run();
  end

  // About 60 frames of some 300 clocks each; twice that is a hang
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    complete_run();
  end
endmodule : tb_shp_serial_host
